// ===== inc/ssd_pkg.sv
package ssd_pkg;
  // Response byte bit positions
  localparam int RSP_OUT_ON = 0;
  localparam int RSP_ACT_DET = 1;
  localparam int RSP_IN_LIVE = 4;
  localparam int RSP_LIMIT = 5;
  localparam int RSP_WARN = 6;
  localparam int RSP_ERR = 7;
  // Detail byte bit positions
  localparam int DET_OUT1 = 0;
  localparam int DET_OUT2 = 1;
  localparam int DET_XSHORT = 2;
  localparam int DET_TEMP = 3;
  localparam int DET_ACTR = 4;
  localparam int DET_INTERNAL = 5;
  localparam int DET_COMM = 6;
  // Request byte error reset bit
  localparam int REQ_RESET = 7;
  // Reset values
  localparam logic [7:0] BYTE_RST = 8'h00;
  // Warning switch-off delay
  localparam longint WARN_DELAY_MIN = 30;
  localparam longint CLK_MHZ = 250;
  localparam longint WARN_DELAY_CYC = WARN_DELAY_MIN * 64'd60 * 64'd1000000 * CLK_MHZ;
  localparam int WARN_CNT_W = 39;
endpackage

// ===== design/ssd_sync.sv
`timescale 1ns/10ps
// Two-stage reset release: asserts at once, deasserts on the clock
module ssd_sync (
  input wire logic clk,
  input wire logic rst_n_in,
  output logic rst_n_out
);
  logic stage_r;

  always_ff @(posedge clk or negedge rst_n_in) begin
    if (!rst_n_in) begin
      stage_r <= 1'b0;
      rst_n_out <= 1'b0;
    end else begin
      stage_r <= 1'b1;
      rst_n_out <= stage_r;
    end
  end
endmodule // ssd_sync

// ===== design/ssd_timer.sv
`timescale 1ns/10ps
// Counts while run is high; expired holds once the limit is reached.
module ssd_timer #(
  parameter logic [38:0] LIMIT = 39'd1
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic run,
  output logic expired
);
  logic [38:0] cnt_r;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_r <= 39'h0;
      expired <= 1'b0;
    end else if (!run) begin
      cnt_r <= 39'h0;
      expired <= 1'b0;
    end else if (cnt_r >= LIMIT - 39'd1) begin
      expired <= 1'b1;
    end else begin
      cnt_r <= cnt_r + 39'd1;
    end
  end
endmodule // ssd_timer

// ===== design/ssd_diag.sv
`timescale 1ns/10ps
//==================================================================
// Sensor diagnostic byte encoder
module ssd_diag #(
  parameter logic [38:0] WARN_DELAY = 39'(ssd_pkg::WARN_DELAY_CYC)
) (
  input wire logic CORE_CLK,
  input wire logic RESET_N,
  input wire logic SAFETY_IN_FIRST,
  input wire logic SAFETY_IN_SECOND,
  input wire logic ACTUATOR_PRESENT,
  input wire logic ACTUATOR_MARGINAL,
  input wire logic ACTUATOR_BAD,
  input wire logic GUARD_OPEN,
  input wire logic FLT_OUT_FIRST,
  input wire logic FLT_OUT_SECOND,
  input wire logic FLT_CROSS_SHORT,
  input wire logic FLT_OVERTEMP,
  input wire logic FLT_INTERNAL,
  input wire logic COMM_OK,
  input wire logic [7:0] FAULT_CLEAR_REQUEST,
  output logic SAFETY_OUT_FIRST,
  output logic SAFETY_OUT_SECOND,
  output logic [7:0] CONDITION_RESPONSE,
  output logic [7:0] WARNING_DETAIL,
  output logic [7:0] ERROR_DETAIL
);
  //================================================================
  // Reset and timing
  logic rst_n;
  logic warn_expired;
  logic req_prev_r;
  logic err_r;
  logic [7:0] err_cause_r;
  logic [7:0] warn_now;
  logic [7:0] err_new;
  logic warn_pending;
  logic outs_on_nxt;
  logic outs_on_r;
  logic clear_cmd;
  logic cause_gone;
  logic out_fault_seen;

  ssd_sync u_sync (
    .clk(CORE_CLK),
    .rst_n_in(RESET_N),
    .rst_n_out(rst_n)
  );

  ssd_timer #(
    .LIMIT(WARN_DELAY)
  ) u_warn_timer (
    .clk(CORE_CLK),
    .rst_n(rst_n),
    .run(warn_pending),
    .expired(warn_expired)
  );

  //================================================================
  // Cause decoding
  always_comb begin
    warn_now = 8'h00;
    err_new = 8'h00;
    warn_now[ssd_pkg::DET_OUT1] = FLT_OUT_FIRST;
    warn_now[ssd_pkg::DET_OUT2] = FLT_OUT_SECOND;
    warn_now[ssd_pkg::DET_XSHORT] = FLT_CROSS_SHORT;
    warn_now[ssd_pkg::DET_TEMP] = FLT_OVERTEMP;
    warn_now[ssd_pkg::DET_COMM] = ~COMM_OK;
    // Internal faults are immediate errors, never a delayed warning
    // bad actuator error
    err_new[ssd_pkg::DET_ACTR] = ACTUATOR_BAD;
    err_new[ssd_pkg::DET_INTERNAL] = FLT_INTERNAL;
    if (warn_expired) begin
      err_new[3:0] = warn_now[3:0];
    end
  end

  // Comm loss alone never starts the warning timer; it reports and holds the outputs
  assign warn_pending = |warn_now[3:0];

  //================================================================
  // Error latch
  // reset on request falling edge
  assign clear_cmd = (req_prev_r & ~FAULT_CLEAR_REQUEST[ssd_pkg::REQ_RESET]) | GUARD_OPEN;
  assign cause_gone = ~ACTUATOR_BAD & ~FLT_INTERNAL & ~FLT_CROSS_SHORT & ~FLT_OVERTEMP;
  // Output faults can only be seen fixed on the next release
  assign out_fault_seen = err_cause_r[ssd_pkg::DET_OUT1] | err_cause_r[ssd_pkg::DET_OUT2];

  always_ff @(posedge CORE_CLK or negedge rst_n) begin
    if (!rst_n) begin
      req_prev_r <= 1'b0;
    end else begin
      req_prev_r <= FAULT_CLEAR_REQUEST[ssd_pkg::REQ_RESET];
    end
  end

  always_ff @(posedge CORE_CLK or negedge rst_n) begin
    if (!rst_n) begin
      err_cause_r <= ssd_pkg::BYTE_RST;
    end else if (|err_new) begin
      // New cause wins over a simultaneous clear
      err_cause_r <= err_cause_r | err_new;
    end else if (clear_cmd && cause_gone && !out_fault_seen) begin
      err_cause_r <= ssd_pkg::BYTE_RST;
    end else if (clear_cmd && cause_gone && GUARD_OPEN) begin
      // Guard opening is the release that clears output faults
      err_cause_r <= ssd_pkg::BYTE_RST;
    end
  end

  assign err_r = |err_cause_r;

  //================================================================
  // Safety outputs
  always_comb begin
    outs_on_nxt = outs_on_r;
    if (COMM_OK) begin
      outs_on_nxt = ACTUATOR_PRESENT & SAFETY_IN_FIRST & SAFETY_IN_SECOND & ~err_r
                    & ~(|err_new);
    end else if (err_r || (|err_new)) begin
      // Safety still wins over holding
      outs_on_nxt = 1'b0;
    end
  end

  always_ff @(posedge CORE_CLK or negedge rst_n) begin
    if (!rst_n) begin
      outs_on_r <= 1'b0;
      SAFETY_OUT_FIRST <= 1'b0;
      SAFETY_OUT_SECOND <= 1'b0;
    end else begin
      outs_on_r <= outs_on_nxt;
      SAFETY_OUT_FIRST <= outs_on_nxt;
      SAFETY_OUT_SECOND <= outs_on_nxt;
    end
  end

  //================================================================
  // Status bytes
  // warning detail always current; error detail keeps latched causes until cleared
  always_ff @(posedge CORE_CLK or negedge rst_n) begin
    if (!rst_n) begin
      CONDITION_RESPONSE <= ssd_pkg::BYTE_RST;
      WARNING_DETAIL <= ssd_pkg::BYTE_RST;
      ERROR_DETAIL <= ssd_pkg::BYTE_RST;
    end else begin
      CONDITION_RESPONSE <= 8'h00;
      CONDITION_RESPONSE[ssd_pkg::RSP_OUT_ON] <= outs_on_nxt;
      CONDITION_RESPONSE[ssd_pkg::RSP_ACT_DET] <= ACTUATOR_PRESENT;
      CONDITION_RESPONSE[ssd_pkg::RSP_IN_LIVE] <= SAFETY_IN_FIRST & SAFETY_IN_SECOND;
      CONDITION_RESPONSE[ssd_pkg::RSP_LIMIT] <= ACTUATOR_MARGINAL & outs_on_nxt;
      CONDITION_RESPONSE[ssd_pkg::RSP_WARN] <= (|warn_now) | err_r | (|err_new);
      CONDITION_RESPONSE[ssd_pkg::RSP_ERR] <= err_r | (|err_new);
      WARNING_DETAIL <= warn_now;
      ERROR_DETAIL <= err_cause_r | err_new;
    end
  end
endmodule // ssd_diag

// ===== verif/ssd_diag_checker.sv
`timescale 1ns/10ps
// ====================
// Port checker
module ssd_diag_checker (
  input wire logic CORE_CLK,
  input wire logic RESET_N,
  input wire logic ACTUATOR_BAD,
  input wire logic COMM_OK,
  input wire logic SAFETY_OUT_FIRST,
  input wire logic SAFETY_OUT_SECOND,
  input wire logic [7:0] CONDITION_RESPONSE,
  input wire logic [7:0] WARNING_DETAIL,
  input wire logic [7:0] ERROR_DETAIL
);
  default clocking cb @(posedge CORE_CLK);
  endclocking
  default disable iff (!RESET_N);
  AST_SPARE: assert property (CONDITION_RESPONSE[3:2] == 2'b00) else $error("spare");
  AST_UNUSED: assert property ({WARNING_DETAIL[7], WARNING_DETAIL[4], ERROR_DETAIL[7:6]} == 4'h0) else $error("unused");
  AST_PAIR: assert property (SAFETY_OUT_SECOND == SAFETY_OUT_FIRST && CONDITION_RESPONSE[0] == SAFETY_OUT_FIRST) else $error("pair");
  AST_ERR_OFF: assert property (CONDITION_RESPONSE[7] |-> !SAFETY_OUT_FIRST && CONDITION_RESPONSE[6]) else $error("err");
  AST_LIMIT: assert property (CONDITION_RESPONSE[5] |-> CONDITION_RESPONSE[0]) else $error("lim");
  AST_BAD: assert property (ACTUATOR_BAD |=> ERROR_DETAIL[4] && CONDITION_RESPONSE[7]) else $error("bad");
  AST_COMM: assert property (!COMM_OK |=> WARNING_DETAIL[6] && CONDITION_RESPONSE[6]) else $error("comm");
  AST_HOLD: assert property (!COMM_OK [*2] |-> !$rose(SAFETY_OUT_FIRST)) else $error("hold");
  cover property (CONDITION_RESPONSE[7]);
  cover property (CONDITION_RESPONSE[5]);
  cover property (!COMM_OK && SAFETY_OUT_FIRST);
endmodule // ssd_diag_checker

bind ssd_diag ssd_diag_checker i_ssd_diag_checker (.CORE_CLK(CORE_CLK), .RESET_N(RESET_N),
  .ACTUATOR_BAD(ACTUATOR_BAD), .COMM_OK(COMM_OK), .SAFETY_OUT_FIRST(SAFETY_OUT_FIRST),
  .SAFETY_OUT_SECOND(SAFETY_OUT_SECOND), .CONDITION_RESPONSE(CONDITION_RESPONSE),
  .WARNING_DETAIL(WARNING_DETAIL), .ERROR_DETAIL(ERROR_DETAIL));

// ===== verif/ssd_gw_model.sv
`timescale 1ns/10ps
// ====================
// Gateway model
module ssd_gw_model (
  input wire logic clk,
  input wire logic clr,
  input wire logic [6:0] junk,
  input wire logic [7:0] rsp,
  input wire logic [7:0] ed,
  output logic [7:0] req,
  output logic [7:0] got_ed
);
  logic [1:0] ph_r = 2'b00;
  // reset bit falls
  // Plain always: the declaration gives the start value, so no second driver
  always @(posedge clk) begin
    ph_r <= clr ? 2'h2 : ph_r - {1'b0, ph_r != 2'h0};
  end
  assign req = {ph_r != 2'h0, junk};
  always_ff @(posedge clk) begin
    if (rsp[7]) got_ed <= ed;
  end
endmodule // ssd_gw_model

// ===== verif/tb.sv
`timescale 1ns/10ps
// ====================
// Bench top
module tb;
  logic clk = 1'b0, rst_n = 1'b0, in1 = 0, in2 = 0, pres = 0, marg = 0, bad = 0;
  logic guard = 0, comm = 1, clr = 0, o1, o2;
  logic [4:0] flt = 0;
  logic [6:0] junk = 0;
  logic [7:0] req, rsp, wd, ed, got;
  int err_count = 0, samples_checked = 0, cyc = 0, seed = 32'h7ffc;
  always #2 clk = ~clk;
  ssd_diag #(.WARN_DELAY(39'h14)) i_ssd_diag (.CORE_CLK(clk), .RESET_N(rst_n),
    .SAFETY_IN_FIRST(in1), .SAFETY_IN_SECOND(in2), .ACTUATOR_PRESENT(pres),
    .ACTUATOR_MARGINAL(marg), .ACTUATOR_BAD(bad), .GUARD_OPEN(guard),
    .FLT_OUT_FIRST(flt[0]), .FLT_OUT_SECOND(flt[1]), .FLT_CROSS_SHORT(flt[2]),
    .FLT_OVERTEMP(flt[3]), .FLT_INTERNAL(flt[4]), .COMM_OK(comm), .FAULT_CLEAR_REQUEST(req),
    .SAFETY_OUT_FIRST(o1), .SAFETY_OUT_SECOND(o2), .CONDITION_RESPONSE(rsp),
    .WARNING_DETAIL(wd), .ERROR_DETAIL(ed));
  ssd_gw_model i_ssd_gw_model (.clk(clk), .clr(clr), .junk(junk), .rsp(rsp), .ed(ed),
    .req(req), .got_ed(got));
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    samples_checked++;
    if (g !== e) begin
      err_count++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  function automatic logic [7:0] rsp_f(input logic w, input logic e);
    logic on;
    on = pres & in1 & in2 & !e;
    return {e, w | e, marg & on, in1 & in2, 2'b00, pres, on};
  endfunction
  task automatic go(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic outs(input logic [7:0] e);
    chk(rsp, e);
    chk({6'h00, o1, o2}, {6'h00, e[0], e[0]});
  endtask
  task automatic pulse;
    clr = 1;
    go(1);
    clr = 0;
    go(6);
  endtask
  task automatic complete_run;
    $display("checked %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      err_count++;
      complete_run();
    end
  end
  initial begin
    go(2);
    rst_n = 1;
    go(3);
    {in1, in2} = 2'b11;
    go(3);
    outs(8'h10);
    for (int i = 0; i < 60; i++) begin
      {junk, in1, in2, pres, marg} = 11'($random(seed));
      marg &= pres;
      go(3);
      outs(rsp_f(0, 0));
    end
    $display("random done");
    {in1, in2, pres, marg} = 4'hE;
    for (int k = 0; k < 4; k++) begin
      flt = 5'(1 << k);
      go(3);
      chk(wd, 8'(1 << k));
      outs(rsp_f(1, 0));
      flt = 0;
      go(3);
      outs(rsp_f(0, 0));
    end
    flt = 5'h08;
    go(25);
    chk(ed, 8'h08);
    pulse();
    outs(rsp_f(0, 1));
    flt = 0;
    pulse();
    outs(rsp_f(0, 0));
    chk(got, 8'h08);
    bad = 1;
    go(1);
    bad = 0;
    go(3);
    chk(ed, 8'h10);
    pulse();
    flt = 5'h10;
    go(3);
    chk(ed, 8'h20);
    {flt, pres, guard} = 7'h01;
    go(4);
    guard = 0;
    outs(rsp_f(0, 0));
    $display("fault done");
    pres = 1;
    go(3);
    comm = 0;
    go(3);
    chk(wd, 8'h40);
    pres = 0;
    go(3);
    chk({6'h00, o1, o2}, 8'h03);
    comm = 1;
    go(3);
    outs(rsp_f(0, 0));
    $display("comm done");
    complete_run();
  end
endmodule // tb
